// *** src/idv_divider.sv ***
// Iterative divide datapath with working registers and Wishbone access
`timescale 1ns/1ps
`include "idv_map.svh"

module idv_divider (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [`IDV_ADR_W-1:0]      wb_adr_i,
    input  wire logic [`IDV_WB_SEL_W-1:0]   wb_sel_i,
    input  wire logic [`IDV_WB_DAT_W-1:0]   wb_dat_i,
    output logic      [`IDV_WB_DAT_W-1:0]   wb_dat_o,
    output logic                            wb_ack_o,
    input  wire idv_pkg::idv_step_t         step_i,
    output logic                            trap_o,
    output logic                            step_done_o,
    output idv_pkg::idv_flags_t             flags_o
);
    import idv_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // size bit and high select; register fields
    function automatic idv_fields_t decode_instr(
        input logic [`IDV_INSTR_W-1:0] instr
    );
        idv_fields_t f;
        f.op      = IDV_OP_NONE;
        f.dbl     = 1'b0;
        f.hi_sel  = instr[`IDV_HI_SEL_HI:`IDV_HI_SEL_LO];
        f.lo_sel  = instr[`IDV_LO_SEL_HI:`IDV_LO_SEL_LO];
        f.dvs_sel = instr[`IDV_DVS_SEL_HI:`IDV_DVS_SEL_LO];
        if (instr[`IDV_OPC_HI:`IDV_OPC_LO] == `IDV_OPC_INT)
        begin
            f.op  = instr[`IDV_UNS_BIT] ? IDV_OP_UNSIGNED : IDV_OP_SIGNED;
            f.dbl = instr[`IDV_SIZE_BIT];
        end
        else if (instr[`IDV_OPC_HI:`IDV_OPC_LO] == `IDV_OPC_FRAC)
        begin
            // Fractional form takes its dividend from the high select
            f.op     = IDV_OP_FRAC;
            f.lo_sel = instr[`IDV_HI_SEL_HI:`IDV_HI_SEL_LO];
        end
        return f;
    endfunction : decode_instr

    function automatic idv_bus_t bus_target(
        input logic [`IDV_ADR_W-1:0] adr
    );
        logic [`IDV_IDX_HI-`IDV_IDX_LO:0] idx;
        idx = adr[`IDV_IDX_HI:`IDV_IDX_LO];
        if (idx <= `IDV_IDX_LAST_WREG)
            return IDV_BUS_WREG;
        else if (idx == `IDV_IDX_STATUS)
            return IDV_BUS_STATUS;
        else
            return IDV_BUS_NONE;
    endfunction : bus_target

    function automatic logic [`IDV_WORD_W-1:0] neg16(
        input logic [`IDV_WORD_W-1:0] v
    );
        return `IDV_WORD_W'(~v + `IDV_WORD_W'(1));
    endfunction : neg16

    // One restoring step on the remainder:quotient pair
    function automatic logic [`IDV_DWORD_W-1:0] div_iter(
        input logic [`IDV_DWORD_W-1:0] rq,
        input logic [`IDV_WORD_W-1:0]  dmag
    );
        logic [`IDV_DWORD_W:0]  sh;
        logic [`IDV_WORD_W:0]   top;
        logic [`IDV_WORD_W:0]   diff;
        sh   = {rq, 1'b0};
        top  = sh[`IDV_DWORD_W:`IDV_WORD_W];
        diff = top - {1'b0, dmag};
        if (top >= {1'b0, dmag})
            return {diff[`IDV_WORD_W-1:0], sh[`IDV_WORD_W-1:1], 1'b1};
        else
            return sh[`IDV_DWORD_W-1:0];
    endfunction : div_iter

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [`IDV_WORD_W-1:0] wreg_r [`IDV_NUM_WREGS];
    idv_flags_t             flags_r;
    idv_flags_t             flags_nxt;
    logic [`IDV_WORD_W-1:0] quo_nxt;
    logic [`IDV_WORD_W-1:0] rem_nxt;
    logic                   exec_nxt;
    logic                   trap_nxt;
    idv_fields_t            fld;
    logic [`IDV_WORD_W-1:0] dvs;
    logic [`IDV_WORD_W-1:0] dmag;
    logic                   dvs_neg;
    logic                   signed_op;
    logic [`IDV_DWORD_W-1:0] num;
    logic [`IDV_DWORD_W-1:0] mag;
    logic [`IDV_DWORD_W-1:0] it;
    logic                   qneg;
    logic                   ack_r;
    logic [`IDV_WB_DAT_W-1:0] rdat_r;
    logic                   trap_r;
    logic                   done_r;
    logic                   bus_req;
    logic                   bus_wr;
    idv_bus_t               bus_tgt;
    logic [`IDV_SEL_W-1:0]  bus_idx;

    ////////////////////////////////////////////////////////////////////////
    // Divide step

    always_comb
    begin
        fld       = decode_instr(step_i.instr);
        dvs       = wreg_r[fld.dvs_sel];
        signed_op = (fld.op == IDV_OP_SIGNED) || (fld.op == IDV_OP_FRAC);
        dvs_neg   = signed_op & dvs[`IDV_WORD_W-1];
        dmag      = dvs_neg ? neg16(dvs) : dvs;
        num       = {wreg_r[`IDV_REM_IDX], wreg_r[`IDV_QUO_IDX]};
        mag       = num;
        it        = num;
        qneg      = 1'b0;
        quo_nxt   = wreg_r[`IDV_QUO_IDX];
        rem_nxt   = wreg_r[`IDV_REM_IDX];
        flags_nxt = flags_r;
        exec_nxt  = 1'b0;
        trap_nxt  = 1'b0;
        if (step_i.valid && fld.op != IDV_OP_NONE)
        begin
            // phase of the sequence follows the repeat count
            if (step_i.rcnt == `IDV_RCNT_LOAD)
            begin
                // zero divisor traps before anything is loaded
                if (dvs == `IDV_WORD_ZERO)
                begin
                    trap_nxt = 1'b1;
                end
                else
                begin
                    exec_nxt     = 1'b1;
                    flags_nxt.ov = 1'b0;
                    // operand selection from the working registers
                    unique case (fld.op)
                        IDV_OP_SIGNED:
                        begin
                            quo_nxt = wreg_r[fld.lo_sel];
                            if (fld.dbl)
                                rem_nxt = wreg_r[fld.hi_sel];
                            else if (wreg_r[fld.lo_sel][`IDV_WORD_W-1])
                                rem_nxt = `IDV_WORD_ONES;
                            else
                                rem_nxt = `IDV_WORD_ZERO;
                        end
                        IDV_OP_UNSIGNED:
                        begin
                            quo_nxt = wreg_r[fld.lo_sel];
                            rem_nxt = fld.dbl ? wreg_r[fld.hi_sel]
                                              : `IDV_WORD_ZERO;
                        end
                        IDV_OP_FRAC:
                        begin
                            quo_nxt = `IDV_WORD_ZERO;
                            rem_nxt = wreg_r[fld.lo_sel];
                        end
                        IDV_OP_NONE:
                        begin
                            exec_nxt = 1'b0;
                        end
                    endcase
                end
            end
            else if (step_i.rcnt == `IDV_RCNT_FINAL)
            begin
                exec_nxt = 1'b1;
                // carry holds the dividend sign up to here
                qneg     = flags_r.c ^ dvs_neg;
                quo_nxt  = qneg ? neg16(wreg_r[`IDV_QUO_IDX])
                                : wreg_r[`IDV_QUO_IDX];
                rem_nxt  = flags_r.c ? neg16(wreg_r[`IDV_REM_IDX])
                                     : wreg_r[`IDV_REM_IDX];
                // signed word overflow: positive quotient of 32768 or more, negative below -32768
                if (signed_op)
                begin
                    if (!qneg && wreg_r[`IDV_QUO_IDX][`IDV_WORD_W-1])
                        flags_nxt.ov = 1'b1;
                    if (qneg && wreg_r[`IDV_QUO_IDX] > `IDV_QUO_NEG_MAX)
                        flags_nxt.ov = 1'b1;
                end
                flags_nxt.n = rem_nxt[`IDV_WORD_W-1];
                flags_nxt.z = (rem_nxt == `IDV_WORD_ZERO);
            end
            else
            begin
                exec_nxt = 1'b1;
                if (step_i.rcnt == `IDV_RCNT_CONV)
                begin
                    // Work on magnitudes; keep dividend sign in carry
                    if (signed_op && num[`IDV_DWORD_W-1])
                        mag = `IDV_DWORD_W'(~num + `IDV_DWORD_W'(1));
                    flags_nxt.c = signed_op & num[`IDV_DWORD_W-1];
                    // overflow stays set until the next load
                    flags_nxt.ov = (mag[`IDV_DWORD_W-1:`IDV_WORD_W] >= dmag);
                    if (fld.op == IDV_OP_FRAC)
                        mag = mag >> 1;
                end
                it      = div_iter(mag, dmag);
                quo_nxt = it[`IDV_WORD_W-1:0];
                rem_nxt = it[`IDV_DWORD_W-1:`IDV_WORD_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone decode

    always_comb
    begin
        bus_req = wb_cyc_i & wb_stb_i;
        // Write lands on the edge where the master sees ack
        bus_wr  = bus_req & wb_we_i & ack_r;
        bus_tgt = bus_target(wb_adr_i);
        bus_idx = wb_adr_i[`IDV_LO_SEL_LO-`IDV_SEL_W+`IDV_SEL_W+
                           `IDV_IDX_LO-`IDV_LO_SEL_LO+`IDV_SEL_W-1:
                           `IDV_IDX_LO];
    end

    ////////////////////////////////////////////////////////////////////////
    // Working registers

    // quotient and remainder hold the partial divide state, the dividend sign sits in carry
    // results written back into the fixed registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < `IDV_NUM_WREGS; i++)
                wreg_r[i] <= `IDV_WORD_ZERO;
        end
        else
        begin
            // Bus writes to the result pair lose against a divide step
            if (bus_wr && bus_tgt == IDV_BUS_WREG)
            begin
                if (wb_sel_i[0])
                    wreg_r[bus_idx][7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    wreg_r[bus_idx][15:8] <= wb_dat_i[15:8];
            end
            if (exec_nxt)
            begin
                wreg_r[`IDV_QUO_IDX] <= quo_nxt;
                wreg_r[`IDV_REM_IDX] <= rem_nxt;
            end
        end
    end

    // flags carry sign and overflow across interrupts
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            flags_r <= '0;
        else if (exec_nxt)
            flags_r <= flags_nxt;
        else if (bus_wr && bus_tgt == IDV_BUS_STATUS && wb_sel_i[0])
        begin
            flags_r.c  <= wb_dat_i[`IDV_ST_C];
            flags_r.z  <= wb_dat_i[`IDV_ST_Z];
            flags_r.ov <= wb_dat_i[`IDV_ST_OV];
            flags_r.n  <= wb_dat_i[`IDV_ST_N];
        end
    end

    assign flags_o = flags_r;

    ////////////////////////////////////////////////////////////////////////
    // Core handshake

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            trap_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            // trap in the first execution cycle
            trap_r <= trap_nxt;
            // every step commits whole, so each boundary is safe
            done_r <= exec_nxt;
        end
    end

    assign trap_o      = trap_r;
    assign step_done_o = done_r;

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= bus_req & ~ack_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdat_r <= `IDV_WB_ZERO;
        else if (bus_req && !ack_r)
        begin
            unique case (bus_tgt)
                IDV_BUS_WREG:
                    rdat_r <= {{(`IDV_WB_DAT_W-`IDV_WORD_W){1'b0}},
                               wreg_r[bus_idx]};
                IDV_BUS_STATUS:
                begin
                    rdat_r              <= `IDV_WB_ZERO;
                    rdat_r[`IDV_ST_C]   <= flags_r.c;
                    rdat_r[`IDV_ST_Z]   <= flags_r.z;
                    rdat_r[`IDV_ST_OV]  <= flags_r.ov;
                    rdat_r[`IDV_ST_N]   <= flags_r.n;
                end
                default:
                    rdat_r <= `IDV_WB_ZERO;
            endcase
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

endmodule : idv_divider

// *** src/idv_map.svh ***
// Constants for the iterative integer and fractional divider
`ifndef IDV_DIVIDER_MAP_SVH
`define IDV_DIVIDER_MAP_SVH

// Data widths
`define IDV_WORD_W          16
`define IDV_DWORD_W         32
`define IDV_INSTR_W         24
`define IDV_RCNT_W          5
`define IDV_SEL_W           4
`define IDV_NUM_WREGS       16

// Fixed working register indices
`define IDV_QUO_IDX         4'h0
`define IDV_REM_IDX         4'h1

// Instruction word layout
`define IDV_OPC_HI          23
`define IDV_OPC_LO          16
`define IDV_OPC_INT         8'hd8
`define IDV_OPC_FRAC        8'hd9
`define IDV_UNS_BIT         15
`define IDV_HI_SEL_HI       14
`define IDV_HI_SEL_LO       11
`define IDV_LO_SEL_HI       10
`define IDV_LO_SEL_LO       7
`define IDV_SIZE_BIT        6
`define IDV_DVS_SEL_HI      3
`define IDV_DVS_SEL_LO      0

// Repeat count phases of one 18-step sequence
`define IDV_RCNT_LOAD       5'h11
`define IDV_RCNT_CONV       5'h10
`define IDV_RCNT_FINAL      5'h00

// Wishbone map, byte addresses
`define IDV_ADR_W           8
`define IDV_WB_DAT_W        32
`define IDV_WB_SEL_W        4
`define IDV_IDX_HI          7
`define IDV_IDX_LO          2
`define IDV_IDX_STATUS      6'h10
`define IDV_IDX_LAST_WREG   6'h0f

// Status register bit positions
`define IDV_ST_C            0
`define IDV_ST_Z            1
`define IDV_ST_OV           2
`define IDV_ST_N            3

// Reset and fill values
`define IDV_WORD_ZERO       16'h0000
`define IDV_WORD_ONES       16'hffff
`define IDV_QUO_NEG_MAX     16'h8000
`define IDV_WB_ZERO         32'h0000_0000

`endif

// *** src/idv_pkg.sv ***
// Types shared by the divider and its users
package idv_pkg;
`include "idv_map.svh"

    typedef enum logic [1:0] {
        IDV_OP_NONE,
        IDV_OP_SIGNED,
        IDV_OP_UNSIGNED,
        IDV_OP_FRAC
    } idv_op_t;

    typedef enum logic [1:0] {
        IDV_BUS_WREG,
        IDV_BUS_STATUS,
        IDV_BUS_NONE
    } idv_bus_t;

    typedef struct packed {
        logic                      valid;
        logic [`IDV_INSTR_W-1:0]   instr;
        logic [`IDV_RCNT_W-1:0]    rcnt;
    } idv_step_t;

    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic c;
    } idv_flags_t;

    typedef struct packed {
        idv_op_t                   op;
        logic                      dbl;
        logic [`IDV_SEL_W-1:0]     hi_sel;
        logic [`IDV_SEL_W-1:0]     lo_sel;
        logic [`IDV_SEL_W-1:0]     dvs_sel;
    } idv_fields_t;

endpackage : idv_pkg

// *** tb/idv_divider_monitor.sv ***
// Concurrent checks on the divider ports
`timescale 1ns/1ps
`include "idv_map.svh"
module idv_divider_monitor (
    input wire logic                       clk_i,
    input wire logic                       rst_i,
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_we_i,
    input wire logic [`IDV_ADR_W-1:0]      wb_adr_i,
    input wire logic [`IDV_WB_SEL_W-1:0]   wb_sel_i,
    input wire logic [`IDV_WB_DAT_W-1:0]   wb_dat_i,
    input wire logic [`IDV_WB_DAT_W-1:0]   wb_dat_o,
    input wire logic                       wb_ack_o,
    input wire idv_pkg::idv_step_t         step_i,
    input wire logic                       trap_o,
    input wire logic                       step_done_o,
    input wire idv_pkg::idv_flags_t        flags_o
);
    import idv_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic div_step;
    logic load_step;
    logic last_step;
    logic bus_wr;
    assign div_step  = step_i.valid &&
        (step_i.instr[`IDV_OPC_HI:`IDV_OPC_LO] == `IDV_OPC_INT ||
         step_i.instr[`IDV_OPC_HI:`IDV_OPC_LO] == `IDV_OPC_FRAC);
    assign load_step = div_step && step_i.rcnt == `IDV_RCNT_LOAD;
    assign last_step = div_step && step_i.rcnt == `IDV_RCNT_FINAL;
    assign bus_wr    = wb_cyc_i && wb_stb_i && wb_we_i;
    ////////////////////////////////////////////////////////////////////////
    ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("bus request not acked next cycle");
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held beyond one cycle");
    upper_zero_a: assert property (wb_ack_o && !wb_we_i |->
        wb_dat_o[31:16] == 16'h0000 && (wb_adr_i[7:2] <= `IDV_IDX_STATUS
        || wb_dat_o == `IDV_WB_ZERO)) else $error("read data not zero");
    step_done_a: assert property (div_step |=> step_done_o ^ trap_o)
        else $error("step neither done nor trapped");
    done_cause_a: assert property (step_done_o |-> $past(div_step))
        else $error("step done without a step");
    trap_cause_a: assert property (trap_o |-> $past(load_step))
        else $error("trap outside first step");
    trap_pulse_a: assert property (trap_o |=> !trap_o)
        else $error("trap longer than one cycle");
    ov_load_clear_a: assert property (load_step |=> trap_o ||
        !flags_o.ov) else $error("overflow not cleared at load");
    flags_hold_a: assert property (!div_step && !bus_wr |=>
        $stable(flags_o)) else $error("flags changed between steps");
    nz_excl_a: assert property (last_step |=> !(flags_o.n && flags_o.z))
        else $error("negative and zero both set");
    cover property (trap_o);
    cover property (last_step ##1 step_done_o);
    cover property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h80);
endmodule : idv_divider_monitor

bind idv_divider idv_divider_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .step_i(step_i),
    .trap_o(trap_o), .step_done_o(step_done_o), .flags_o(flags_o));

// *** tb/idv_core_model.sv ***
// Decoder and repeat-loop stand-in issuing divide steps
`timescale 1ns/1ps
module idv_core_model (
    input  wire logic             clk_i,
    input  wire logic             go_i,
    input  wire logic [23:0]      instr_i,
    input  wire logic [3:0]       gap_i,
    input  wire logic             trap_i,
    output idv_pkg::idv_step_t    step_o,
    output logic                  busy_o
);
    import idv_pkg::*;
    int k;
    int g;
    bit stop;
    initial
    begin
        step_o = '0;
        busy_o = 1'b0;
    end
    always @(posedge clk_i)
    begin
        if (go_i && !busy_o)
        begin
            busy_o <= 1'b1;
            stop = 1'b0;
            for (k = 17; k >= 0 && !stop; k--)
            begin
                step_o <= '{1'b1, instr_i, 5'(k)};
                @(posedge clk_i);
                // interrupt gaps; one idle after load to see a trap
                g = (k == 17 && gap_i == 4'h0) ? 1 : int'(gap_i);
                // Idle bus shows junk, not the last step
                if (g > 0 || k == 0)
                    step_o <= '{1'b0, ~instr_i, ~5'(k)};
                repeat (g)
                begin
                    @(posedge clk_i);
                    if (trap_i)
                        stop = 1'b1;
                end
            end
            busy_o <= 1'b0;
        end
    end
endmodule : idv_core_model

// *** tb/idv_divider_test.sv ***
// Self-checking bench for the iterative divider
`timescale 1ns/1ps
`include "idv_map.svh"
module idv_divider_test;
    import idv_pkg::*;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        trap_o;
    logic        step_done_o;
    logic        go       = 1'b0;
    logic        busy;
    logic [23:0] ins      = 24'h0;
    logic [3:0]  gap      = 4'h0;
    idv_step_t   step_i;
    idv_flags_t  flags_o;
    int          failures = 0;
    int          n_checks = 0;
    int          n_traps  = 0;
    int          n_done   = 0;
    logic [31:0] r;

    always #4 clk_i = ~clk_i;
    always @(posedge clk_i)
        if (trap_o === 1'b1)
            n_traps <= n_traps + 1;
    always @(posedge clk_i)
        if (step_done_o === 1'b1)
            n_done <= n_done + 1;

    idv_divider dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .step_i(step_i), .trap_o(trap_o),
        .step_done_o(step_done_o), .flags_o(flags_o));
    idv_core_model core (.clk_i(clk_i), .go_i(go), .instr_i(ins),
        .gap_i(gap), .trap_i(trap_o), .step_o(step_i), .busy_o(busy));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Classic single cycle; called just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        n = 0;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("bus ack", 32'h1, {31'h0, wb_ack_o});
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic rd(input string w, input logic [7:0] a,
                      input logic [31:0] e);
        wb(1'b0, a, 4'hf, 32'h0);
        chk(w, e, r);
    endtask : rd

    function automatic logic [23:0] mk(input bit f, u, d,
                                       input logic [3:0] h, l, s);
        return {f ? `IDV_OPC_FRAC : `IDV_OPC_INT, u, h, l, d, 2'b00, s};
    endfunction : mk

    task automatic div_case(input logic [23:0] i, input logic [3:0] ra, rb,
        rs, input logic [15:0] va, vb, vs, input logic [3:0] g,
        input logic [15:0] eq, er, input logic [2:0] ef, input bit full);
        int n;
        int d0;
        wb(1'b1, 8'h00, 4'hf, 32'h5555);
        wb(1'b1, 8'h04, 4'hf, 32'h1234);
        wb(1'b1, {2'b00, rb, 2'b00}, 4'hf, {16'h0, vb});
        wb(1'b1, {2'b00, ra, 2'b00}, 4'hf, {16'h0, va});
        wb(1'b1, {2'b00, rs, 2'b00}, 4'hf, {16'h0, vs});
        ins <= i;
        gap <= g;
        d0 = n_done;
        go  <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (busy && n < 200);
        wb(1'b0, 8'h40, 4'hf, 32'h0);
        chk("overflow flag", {31'h0, ef[1]}, {31'h0, r[2]});
        chk("step count", vs == 16'h0 ? 32'd0 : 32'd18, n_done - d0);
        if (full)
        begin
            chk("flags", {29'h0, ef}, {29'h0, r[3:1]});
            chk("flag port", {29'h0, ef}, {29'h0, flags_o[3:1]});
            rd("quotient", 8'h00, {16'h0, eq});
            rd("remainder", 8'h04, {16'h0, er});
        end
    endtask : div_case

    task automatic print_verdict();
        $display("Checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk_i);
        failures++;
        print_verdict();
    end

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd("reset quotient", 8'h00, 32'h0);
        rd("reset status", 8'h40, 32'h0);
        rd("unmapped read", 8'h80, 32'h0);
        wb(1'b1, 8'h14, 4'hf, 32'hffff_ffff);
        rd("upper bits", 8'h14, 32'h0000_ffff);
        wb(1'b1, 8'h14, 4'h1, 32'h0000_0012);
        rd("byte lane", 8'h14, 32'h0000_ff12);
        wb(1'b1, 8'h40, 4'h1, 32'h0000_000f);
        rd("status write", 8'h40, 32'h0000_000f);
        div_case(mk(0, 0, 0, 0, 3, 4), 3, 3, 4, 16'h3000, 16'h3000,
            16'h0027, 0, 16'h013b, 16'h0003, 3'b000, 1);
        div_case(mk(0, 0, 0, 0, 3, 4), 3, 3, 4, 16'hfff9, 16'hfff9,
            16'h0002, 2, 16'hfffd, 16'hffff, 3'b100, 1);
        div_case(mk(0, 0, 0, 0, 3, 4), 3, 3, 4, 16'h0006, 16'h0006,
            16'hfffd, 0, 16'hfffe, 16'h0000, 3'b001, 1);
        div_case(mk(0, 0, 0, 0, 3, 4), 3, 3, 4, 16'h8000, 16'h8000,
            16'hffff, 0, 16'h0, 16'h0, 3'b010, 0);
        div_case(mk(0, 0, 1, 7, 6, 4), 6, 7, 4, 16'h0005, 16'h0001,
            16'h0100, 1, 16'h0100, 16'h0005, 3'b000, 1);
        div_case(mk(0, 0, 1, 7, 6, 4), 6, 7, 4, 16'h0000, 16'h0002,
            16'h0001, 0, 16'h0, 16'h0, 3'b010, 0);
        div_case(mk(0, 1, 0, 0, 2, 4), 2, 2, 4, 16'h8000, 16'h8000,
            16'h0200, 0, 16'h0040, 16'h0000, 3'b001, 1);
        div_case(mk(0, 1, 0, 0, 2, 4), 2, 2, 4, 16'hfff9, 16'hfff9,
            16'h0002, 0, 16'h7ffc, 16'h0001, 3'b000, 1);
        div_case(mk(0, 1, 1, 4'hb, 4'ha, 4'hc), 4'ha, 4'hb, 4'hc, 16'h2500,
            16'h0042, 16'h2200, 0, 16'h01f2, 16'h0100, 3'b000, 1);
        div_case(mk(1, 0, 0, 8, 0, 9), 8, 8, 9, 16'h1000, 16'h1000,
            16'h4000, 0, 16'h2000, 16'h0000, 3'b001, 1);
        div_case(mk(1, 0, 0, 8, 0, 9), 8, 8, 9, 16'h1000, 16'h1000,
            16'h8000, 0, 16'hf000, 16'h0000, 3'b001, 1);
        div_case(mk(1, 0, 0, 8, 0, 9), 8, 8, 9, 16'hf000, 16'hf000,
            16'h3000, 3, 16'hd556, 16'he000, 3'b100, 1);
        div_case(mk(1, 0, 0, 8, 0, 9), 8, 8, 9, 16'h4000, 16'h4000,
            16'h1000, 0, 16'h0, 16'h0, 3'b010, 0);
        div_case(mk(0, 0, 0, 0, 3, 4), 3, 3, 4, 16'h3000, 16'h3000,
            16'h0027, 0, 16'h013b, 16'h0003, 3'b000, 1);
        div_case(mk(0, 0, 0, 0, 3, 5), 3, 3, 5, 16'h0042, 16'h0042,
            16'h0000, 0, 16'h0, 16'h0, 3'b000, 0);
        chk("trap count", 32'h1, n_traps);
        rd("quotient kept", 8'h00, 32'h5555);
        rd("remainder kept", 8'h04, 32'h1234);
        print_verdict();
    end
endmodule : idv_divider_test
